// file: hw/ssps_params.svh
`ifndef SSPS_PARAMS_SVH
`define SSPS_PARAMS_SVH

`define SSPS_NUM_PORTS 6
`define SSPS_CLK_HZ 50000000
`define SSPS_TIMEOUT_S 30
`define SSPS_TIMEOUT_CYC (`SSPS_TIMEOUT_S * `SSPS_CLK_HZ)
`define SSPS_NO_PORT 3'h7
`define SSPS_SER_WEEK_W 6
`define SSPS_SER_YEAR_W 3
`define SSPS_SER_CNT_W 11
`define SSPS_SER_W 20
`define SSPS_SER_WEEK_MAX 6'h34
`define SSPS_SER_BASE_YEAR 2014
`define SSPS_FIX_NONE 4'h0
`define SSPS_FIX_GNSS 4'h1
`define SSPS_MSG24B 6'h18
`define SSPS_MSG15 6'h0f

`endif

// file: hw/ssps_pkg.sv
package ssps_pkg;

    // Sentence classes seen on a port, encoded in four bits
    typedef enum logic [3:0] {
        SSPS_S_RMC = 4'h0,
        SSPS_S_GGA = 4'h1,
        SSPS_S_GNS = 4'h2,
        SSPS_S_GLL = 4'h3,
        SSPS_S_GBS = 4'h4,
        SSPS_S_GRS = 4'h5,
        SSPS_S_GSA = 4'h6,
        SSPS_S_GSV = 4'h7,
        SSPS_S_GFA = 4'h8,
        SSPS_S_VTG = 4'h9,
        SSPS_S_VBW = 4'ha,
        SSPS_S_HDT = 4'hb,
        SSPS_S_THS = 4'hc,
        SSPS_S_ROT = 4'hd,
        SSPS_S_DTM = 4'he,
        SSPS_S_OTHER = 4'hf
    } ssps_sent_e;

    typedef enum logic [1:0] {
        SSPS_SR_IDLE = 2'h1,
        SSPS_SR_SEND = 2'h2
    } ssps_sr_state_e;

    typedef logic [2:0] ssps_port_t;

endpackage : ssps_pkg

// file: hw/ssps_selector.sv
`timescale 1ns/1ps
`include "ssps_params.svh"

// What this block does
// [R01] Six ports ranked, sensor one highest
// [R02] Each quantity uses highest ranked qualifying port
// [R03] Position prefers port with RMC and datum
// [R04] Without RMC, datum plus GGA/GNS/GLL qualifies
// [R05] Position sentences dropped unless from position source
// [R06] 30 s position silence drops, reselects
// [R07] Course source: RMC with datum, VTG, VBW
// [R08] VTG/VBW dropped unless from course source
// [R09] 30 s course silence drops, reselects
// [R10] Heading source: HDT or THS
// [R11] HDT/THS dropped unless from heading source
// [R12] 30 s heading silence drops, reselects
// [R13] Turn rate source: ROT
// [R14] ROT dropped unless from turn source
// [R15] 30 s turn rate silence drops, reselects
// [R16] Compatibility reports only none or GNSS fix
// [R17] Compatibility setting kept per port
// [R18] Serial packed week, years, count
// [R19] Serial sent in 24B on 15 request
// [R20] Silence timer restarts on data, clears reselect
module ssps_selector
    import ssps_pkg::*;
#(
    parameter int NPORT = `SSPS_NUM_PORTS,
    parameter int TIMEOUT_CYC = `SSPS_TIMEOUT_CYC,
    parameter int STALE_CYC = `SSPS_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Sentence strobe from the port parsers
    input wire logic sent_stb,
    input wire logic [2:0] sent_port,
    input wire logic [3:0] sent_kind,
    input wire logic sent_datum_ok,
    input wire logic [3:0] sent_fix_quality,
    // Per-port compatibility switches
    input wire logic [NPORT-1:0] compat_mode,
    // Serial number fields
    input wire logic [5:0] ser_week,
    input wire logic [3:0] ser_years,
    input wire logic [10:0] ser_count,
    // Interrogation request
    input wire logic interrog_stb,
    input wire logic [5:0] interrog_msg_id,
    // Forwarded sentence
    output logic fwd_stb,
    output logic [2:0] fwd_port,
    output logic [3:0] fwd_kind,
    output logic [3:0] fwd_fix_quality,
    // Selected sources
    output logic pos_valid,
    output logic [2:0] pos_port,
    output logic cog_valid,
    output logic [2:0] cog_port,
    output logic hdg_valid,
    output logic [2:0] hdg_port,
    output logic rot_valid,
    output logic [2:0] rot_port,
    // Static report reply
    output logic reply_stb,
    output logic [5:0] reply_msg_id,
    output logic [19:0] reply_serial
);
    typedef struct packed {
        logic [NPORT-1:0] seen_rmc;
        logic [NPORT-1:0] seen_dtm;
        logic [NPORT-1:0] seen_fix;
        logic [NPORT-1:0] seen_vel;
        logic [NPORT-1:0] seen_hdg;
        logic [NPORT-1:0] seen_rot;
        logic [31:0] stale_tmr;
        logic fwd_stb;
        logic [2:0] fwd_port;
        logic [3:0] fwd_kind;
        logic [3:0] fwd_fix;
        logic [2:0] pos_port;
        logic pos_valid;
        logic [2:0] cog_port;
        logic cog_valid;
        logic [2:0] hdg_port;
        logic hdg_valid;
        logic [2:0] rot_port;
        logic rot_valid;
        ssps_sr_state_e sr_state;
        logic reply_stb;
        logic [19:0] serial;
    } ssps_sel_s;

    ssps_sel_s st_ff;
    ssps_sel_s nxt_st;
    logic rst_n;
    // Own register: it answers to the raw reset, the struct to the released one
    logic [1:0] rst_sync_ff;

    logic [NPORT-1:0] q_pos, q_cog, q_hdg, q_rot;
    logic [NPORT-1:0] d_pos, d_cog, d_hdg, d_rot;
    logic any_rmc;
    logic [NPORT-1:0] port_hit;
    logic [3:0] k;
    logic pos_v, cog_v, hdg_v, rot_v;
    ssps_port_t pos_p, cog_p, hdg_p, rot_p;

    // Reset released through two flops
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    assign k = sent_kind;
    assign port_hit = sent_stb ? (NPORT'(1) << sent_port) : '0;
    assign any_rmc = |(st_ff.seen_rmc & st_ff.seen_dtm);

    // Qualification per quantity
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            q_pos[i] = st_ff.seen_dtm[i] &&
                       (any_rmc ? st_ff.seen_rmc[i] : st_ff.seen_fix[i]); // R03 R04
            q_cog[i] = (st_ff.seen_rmc[i] && st_ff.seen_dtm[i]) || st_ff.seen_vel[i]; // R07
            q_hdg[i] = st_ff.seen_hdg[i]; // R10
            q_rot[i] = st_ff.seen_rot[i]; // R13
        end
        d_pos = '0;
        d_cog = '0;
        d_hdg = '0;
        d_rot = '0;
        if (sent_stb) begin
            if (k == SSPS_S_RMC || k == SSPS_S_GGA || k == SSPS_S_GNS || k == SSPS_S_GLL) begin
                d_pos = port_hit;
            end
            if (k == SSPS_S_VTG || k == SSPS_S_VBW || (k == SSPS_S_RMC && sent_datum_ok)) begin
                d_cog = port_hit;
            end
            if (k == SSPS_S_HDT || k == SSPS_S_THS) begin
                d_hdg = port_hit;
            end
            if (k == SSPS_S_ROT) begin
                d_rot = port_hit;
            end
        end
    end

    ssps_source_track #(.NPORT(NPORT), .TIMEOUT_CYC(TIMEOUT_CYC)) u_pos (
        .clk(ref_clk), .rst_n(rst_n), .qual(q_pos), .data_stb(d_pos),
        .sel_valid(pos_v), .sel_port(pos_p), .accept()
    );
    ssps_source_track #(.NPORT(NPORT), .TIMEOUT_CYC(TIMEOUT_CYC)) u_cog (
        .clk(ref_clk), .rst_n(rst_n), .qual(q_cog), .data_stb(d_cog),
        .sel_valid(cog_v), .sel_port(cog_p), .accept()
    );
    ssps_source_track #(.NPORT(NPORT), .TIMEOUT_CYC(TIMEOUT_CYC)) u_hdg (
        .clk(ref_clk), .rst_n(rst_n), .qual(q_hdg), .data_stb(d_hdg),
        .sel_valid(hdg_v), .sel_port(hdg_p), .accept()
    );
    ssps_source_track #(.NPORT(NPORT), .TIMEOUT_CYC(TIMEOUT_CYC)) u_rot (
        .clk(ref_clk), .rst_n(rst_n), .qual(q_rot), .data_stb(d_rot),
        .sel_valid(rot_v), .sel_port(rot_p), .accept()
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.fwd_stb = 1'b0;
        nxt_st.reply_stb = 1'b0;
        // Capability memory ages out so a dead port loses its claim
        if (st_ff.stale_tmr >= 32'(STALE_CYC - 1)) begin
            nxt_st.stale_tmr = '0;
            nxt_st.seen_rmc = '0;
            nxt_st.seen_dtm = '0;
            nxt_st.seen_fix = '0;
            nxt_st.seen_vel = '0;
            nxt_st.seen_hdg = '0;
            nxt_st.seen_rot = '0;
        end else begin
            nxt_st.stale_tmr = st_ff.stale_tmr + 32'h1;
        end
        if (sent_stb && sent_port < 3'(NPORT)) begin
            case (k)
                SSPS_S_RMC: nxt_st.seen_rmc = nxt_st.seen_rmc | port_hit;
                SSPS_S_DTM: begin
                    if (sent_datum_ok) begin
                        nxt_st.seen_dtm = nxt_st.seen_dtm | port_hit;
                    end else begin
                        nxt_st.seen_dtm = nxt_st.seen_dtm & ~port_hit;
                    end
                end
                SSPS_S_GGA, SSPS_S_GNS, SSPS_S_GLL: nxt_st.seen_fix = nxt_st.seen_fix | port_hit;
                SSPS_S_VTG, SSPS_S_VBW: nxt_st.seen_vel = nxt_st.seen_vel | port_hit;
                SSPS_S_HDT, SSPS_S_THS: nxt_st.seen_hdg = nxt_st.seen_hdg | port_hit;
                SSPS_S_ROT: nxt_st.seen_rot = nxt_st.seen_rot | port_hit;
                default: ;
            endcase
            // Forwarding gate: only the selected source passes; DTM and other kinds pass from any port
            case (k)
                SSPS_S_RMC, SSPS_S_GGA, SSPS_S_GNS, SSPS_S_GLL, SSPS_S_GBS,
                SSPS_S_GRS, SSPS_S_GSA, SSPS_S_GSV, SSPS_S_GFA:
                    nxt_st.fwd_stb = pos_v && pos_p == sent_port; // R05
                SSPS_S_VTG, SSPS_S_VBW:
                    nxt_st.fwd_stb = cog_v && cog_p == sent_port; // R08
                SSPS_S_HDT, SSPS_S_THS:
                    nxt_st.fwd_stb = hdg_v && hdg_p == sent_port; // R11
                SSPS_S_ROT:
                    nxt_st.fwd_stb = rot_v && rot_p == sent_port; // R14
                default:
                    nxt_st.fwd_stb = 1'b1;
            endcase
            nxt_st.fwd_port = sent_port;
            nxt_st.fwd_kind = sent_kind;
            if (compat_mode[sent_port]) begin // R17
                nxt_st.fwd_fix = (sent_fix_quality == `SSPS_FIX_NONE) ? `SSPS_FIX_NONE : `SSPS_FIX_GNSS; // R16
            end else begin
                nxt_st.fwd_fix = sent_fix_quality; // R16
            end
        end
        nxt_st.pos_valid = pos_v;
        nxt_st.pos_port = pos_p;
        nxt_st.cog_valid = cog_v;
        nxt_st.cog_port = cog_p;
        nxt_st.hdg_valid = hdg_v;
        nxt_st.hdg_port = hdg_p;
        nxt_st.rot_valid = rot_v;
        nxt_st.rot_port = rot_p;
        // Serial reply on interrogation
        case (st_ff.sr_state)
            SSPS_SR_IDLE: begin
                if (interrog_stb && interrog_msg_id == `SSPS_MSG15) begin // R19
                    nxt_st.serial = {ser_week, ser_years[2:0], ser_count}; // R18
                    nxt_st.sr_state = SSPS_SR_SEND;
                end
            end
            SSPS_SR_SEND: begin
                nxt_st.reply_stb = 1'b1; // R19
                nxt_st.sr_state = SSPS_SR_IDLE;
            end
            default: nxt_st.sr_state = SSPS_SR_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff.seen_rmc <= '0;
            st_ff.seen_dtm <= '0;
            st_ff.seen_fix <= '0;
            st_ff.seen_vel <= '0;
            st_ff.seen_hdg <= '0;
            st_ff.seen_rot <= '0;
            st_ff.stale_tmr <= 32'h0;
            st_ff.fwd_stb <= 1'b0;
            st_ff.fwd_port <= 3'h0;
            st_ff.fwd_kind <= 4'h0;
            st_ff.fwd_fix <= 4'h0;
            st_ff.pos_port <= `SSPS_NO_PORT;
            st_ff.pos_valid <= 1'b0;
            st_ff.cog_port <= `SSPS_NO_PORT;
            st_ff.cog_valid <= 1'b0;
            st_ff.hdg_port <= `SSPS_NO_PORT;
            st_ff.hdg_valid <= 1'b0;
            st_ff.rot_port <= `SSPS_NO_PORT;
            st_ff.rot_valid <= 1'b0;
            st_ff.sr_state <= SSPS_SR_IDLE;
            st_ff.reply_stb <= 1'b0;
            st_ff.serial <= 20'h0;
        end else begin
            st_ff.seen_rmc <= nxt_st.seen_rmc;
            st_ff.seen_dtm <= nxt_st.seen_dtm;
            st_ff.seen_fix <= nxt_st.seen_fix;
            st_ff.seen_vel <= nxt_st.seen_vel;
            st_ff.seen_hdg <= nxt_st.seen_hdg;
            st_ff.seen_rot <= nxt_st.seen_rot;
            st_ff.stale_tmr <= nxt_st.stale_tmr;
            st_ff.fwd_stb <= nxt_st.fwd_stb;
            st_ff.fwd_port <= nxt_st.fwd_port;
            st_ff.fwd_kind <= nxt_st.fwd_kind;
            st_ff.fwd_fix <= nxt_st.fwd_fix;
            st_ff.pos_port <= nxt_st.pos_port;
            st_ff.pos_valid <= nxt_st.pos_valid;
            st_ff.cog_port <= nxt_st.cog_port;
            st_ff.cog_valid <= nxt_st.cog_valid;
            st_ff.hdg_port <= nxt_st.hdg_port;
            st_ff.hdg_valid <= nxt_st.hdg_valid;
            st_ff.rot_port <= nxt_st.rot_port;
            st_ff.rot_valid <= nxt_st.rot_valid;
            st_ff.sr_state <= nxt_st.sr_state;
            st_ff.reply_stb <= nxt_st.reply_stb;
            st_ff.serial <= nxt_st.serial;
        end
    end

    assign fwd_stb = st_ff.fwd_stb;
    assign fwd_port = st_ff.fwd_port;
    assign fwd_kind = st_ff.fwd_kind;
    assign fwd_fix_quality = st_ff.fwd_fix;
    assign pos_valid = st_ff.pos_valid;
    assign pos_port = st_ff.pos_port;
    assign cog_valid = st_ff.cog_valid;
    assign cog_port = st_ff.cog_port;
    assign hdg_valid = st_ff.hdg_valid;
    assign hdg_port = st_ff.hdg_port;
    assign rot_valid = st_ff.rot_valid;
    assign rot_port = st_ff.rot_port;
    assign reply_stb = st_ff.reply_stb;
    assign reply_msg_id = `SSPS_MSG24B;
    assign reply_serial = st_ff.serial;
endmodule : ssps_selector

// file: hw/ssps_source_track.sv
`timescale 1ns/1ps
`include "ssps_params.svh"

module ssps_source_track
    import ssps_pkg::*;
#(
    parameter int NPORT = 6,
    parameter int TIMEOUT_CYC = 1500000000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Per-port qualification and data strobes
    input wire logic [NPORT-1:0] qual,
    input wire logic [NPORT-1:0] data_stb,
    // Selected source
    output logic sel_valid,
    output ssps_port_t sel_port,
    output logic accept
);
    typedef struct packed {
        logic valid;
        ssps_port_t port;
        logic [31:0] tmr;
        logic acc;
    } ssps_trk_s;

    ssps_trk_s st_ff;
    ssps_trk_s nxt_st;
    logic found;
    ssps_port_t best;

    // Lowest index is the highest priority
    always_comb begin
        found = 1'b0;
        best = `SSPS_NO_PORT;
        for (int i = NPORT - 1; i >= 0; i--) begin
            if (qual[i]) begin // R01
                found = 1'b1;
                best = ssps_port_t'(i);
            end
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.acc = 1'b0;
        if (!st_ff.valid) begin
            if (found) begin // R02
                nxt_st.valid = 1'b1;
                nxt_st.port = best;
                nxt_st.tmr = '0; // R20
            end
        end else if (best != st_ff.port) begin
            // Better source appeared or current one lost its claim
            nxt_st.valid = found; // R02 R03
            nxt_st.port = best; // R02
            nxt_st.tmr = '0; // R20
        end else if (data_stb[st_ff.port]) begin
            nxt_st.acc = 1'b1;
            nxt_st.tmr = '0; // R20
        end else if (st_ff.tmr >= 32'(TIMEOUT_CYC - 1)) begin
            // Silence: drop, reselect next cycle
            nxt_st.valid = 1'b0; // R06 R09 R12 R15
            nxt_st.port = `SSPS_NO_PORT;
            nxt_st.tmr = '0;
        end else begin
            nxt_st.tmr = st_ff.tmr + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{valid: 1'b0, port: `SSPS_NO_PORT, tmr: 32'h0, acc: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sel_valid = st_ff.valid;
    assign sel_port = st_ff.port;
    assign accept = st_ff.acc;
endmodule : ssps_source_track

// file: sim/sensor_source_priority_selector_test.sv
`timescale 1ns/1ps
module sensor_source_priority_selector_test
    import ssps_pkg::*;
;
    localparam int TOC = 200;
    localparam int STC = 1000;
    logic ref_clk, rstn, interrog_stb, sent_stb, sent_datum_ok, fwd_stb, reply_stb;
    logic pos_valid, cog_valid, hdg_valid, rot_valid;
    logic [5:0] compat_mode, ser_week, interrog_msg_id, reply_msg_id;
    logic [3:0] ser_years, sent_kind, sent_fix_quality, fwd_kind, fwd_fix_quality;
    logic [10:0] ser_count;
    logic [2:0] sent_port, fwd_port, pos_port, cog_port, hdg_port, rot_port;
    logic [19:0] reply_serial;
    int mismatches, comparisons, cyc, p;
    logic [3:0] q;

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    ssps_selector #(.TIMEOUT_CYC(TOC), .STALE_CYC(STC)) DUT (
        .ref_clk(ref_clk), .rstn(rstn), .sent_stb(sent_stb), .sent_port(sent_port), .sent_kind(sent_kind),
        .sent_datum_ok(sent_datum_ok), .sent_fix_quality(sent_fix_quality), .compat_mode(compat_mode),
        .ser_week(ser_week), .ser_years(ser_years), .ser_count(ser_count), .interrog_stb(interrog_stb),
        .interrog_msg_id(interrog_msg_id), .fwd_stb(fwd_stb), .fwd_port(fwd_port), .fwd_kind(fwd_kind),
        .fwd_fix_quality(fwd_fix_quality), .pos_valid(pos_valid), .pos_port(pos_port), .cog_valid(cog_valid),
        .cog_port(cog_port), .hdg_valid(hdg_valid), .hdg_port(hdg_port), .rot_valid(rot_valid),
        .rot_port(rot_port), .reply_stb(reply_stb), .reply_msg_id(reply_msg_id), .reply_serial(reply_serial));

    ssps_sensor_model u_sens (.clk(ref_clk), .sent_stb(sent_stb), .sent_port(sent_port), .sent_kind(sent_kind),
        .sent_datum_ok(sent_datum_ok), .sent_fix_quality(sent_fix_quality));

    task chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task waitc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : waitc

    // Returns at the negedge where the forwarded pulse stands
    task sendc(input int pt, input logic [3:0] k, input logic d, input logic [3:0] fq);
        u_sens.put(pt[2:0], k, d, fq);
    endtask : sendc

    function automatic logic [3:0] exp_fix(input logic c, input logic [3:0] fq);
        return c ? {3'h0, fq != 4'h0} : fq;
    endfunction : exp_fix

    function automatic logic [19:0] exp_ser(input logic [5:0] w, input logic [3:0] y, input logic [10:0] n);
        return {w, y[2:0], n};
    endfunction : exp_ser

    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    // Hang guard, far above the few thousand cycles the tests take
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            summarize();
        end
    end

    initial begin
        rstn = 1'b0;
        interrog_stb = 1'b0;
        interrog_msg_id = 6'h00;
        compat_mode = 6'h00;
        ser_week = 6'h00;
        ser_years = 4'h0;
        ser_count = 11'h000;
        void'($urandom(24318));
        waitc(20);
        rstn = 1'b1;
        waitc(3);
        chk("pos_port", pos_port, 3'h7);
        sendc(1, SSPS_S_HDT, 1'b1, 4'h1);
        waitc(3);
        chk("hdg_port", {hdg_valid, hdg_port}, 4'h9);
        sendc(2, SSPS_S_HDT, 1'b1, 4'h1);
        chk("fwd_stb", fwd_stb, 1'b0);
        sendc(1, SSPS_S_HDT, 1'b1, 4'h1);
        chk("fwd_stb", fwd_stb, 1'b1);
        sendc(0, SSPS_S_THS, 1'b1, 4'h1);
        waitc(3);
        chk("hdg_port", hdg_port, 3'h0);
        $display("heading test done");
        sendc(5, SSPS_S_ROT, 1'b1, 4'h1);
        waitc(3);
        chk("rot_port", {rot_valid, rot_port}, 4'hd);
        sendc(4, SSPS_S_ROT, 1'b1, 4'h1);
        waitc(3);
        chk("rot_port", rot_port, 3'h4);
        sendc(5, SSPS_S_ROT, 1'b1, 4'h1);
        chk("fwd_stb", fwd_stb, 1'b0);
        sendc(4, SSPS_S_ROT, 1'b1, 4'h1);
        chk("fwd_stb", fwd_stb, 1'b1);
        $display("turn rate test done");
        sendc(3, SSPS_S_DTM, 1'b1, 4'h1);
        sendc(3, SSPS_S_GGA, 1'b1, 4'h1);
        waitc(3);
        chk("pos_port", {pos_valid, pos_port}, 4'hb);
        sendc(4, SSPS_S_DTM, 1'b1, 4'h1);
        sendc(4, SSPS_S_RMC, 1'b1, 4'h1);
        waitc(3);
        chk("pos_port", pos_port, 3'h4);
        chk("cog_port", {cog_valid, cog_port}, 4'hc);
        // RMC from port 3 would take over, so the loop starts past it
        for (int k = 1; k <= 8; k++) begin
            sendc(3, k[3:0], 1'b1, 4'h1);
            chk("fwd_stb", fwd_stb, 1'b0);
            sendc(4, k[3:0], 1'b1, 4'h1);
            chk("fwd_stb", fwd_stb, 1'b1);
        end
        $display("position test done");
        sendc(2, SSPS_S_VTG, 1'b1, 4'h1);
        waitc(3);
        chk("cog_port", cog_port, 3'h2);
        sendc(5, SSPS_S_VBW, 1'b1, 4'h1);
        chk("fwd_stb", fwd_stb, 1'b0);
        sendc(2, SSPS_S_VBW, 1'b1, 4'h1);
        chk("fwd_stb", fwd_stb, 1'b1);
        $display("course test done");
        repeat (3) begin
            waitc(150);
            sendc(0, SSPS_S_THS, 1'b1, 4'h1);
            chk("fwd_stb", fwd_stb, 1'b1);
            chk("hdg_port", hdg_port, 3'h0);
        end
        waitc(2 * (TOC + STC) + 10);
        chk("valids", {pos_valid, cog_valid, hdg_valid, rot_valid}, 4'h0);
        $display("silence test done");
        compat_mode = 6'($urandom());
        repeat (24) begin
            p = $urandom_range(5);
            q = 4'($urandom());
            sendc(p, SSPS_S_OTHER, 1'b0, q);
            chk("fwd_stb", fwd_stb, 1'b1);
            chk("fwd_fix", fwd_fix_quality, exp_fix(compat_mode[p], q));
        end
        $display("compat test done");
        for (int i = 0; i < 6; i++) begin
            ser_week = (i == 0) ? 6'h34 : 6'($urandom_range(52));
            ser_years = 4'($urandom_range(7));
            ser_count = (i == 2) ? 11'h7ff : 11'($urandom());
            interrog_msg_id = i[0] ? 6'h0e : 6'h0f;
            interrog_stb = 1'b1;
            waitc(1);
            interrog_stb = 1'b0;
            waitc(1);
            chk("reply_stb", reply_stb, !i[0]);
            if (!i[0]) begin
                chk("serial", reply_serial, exp_ser(ser_week, ser_years, ser_count));
                chk("reply_msg_id", reply_msg_id, 6'h18);
            end
            waitc(2);
        end
        $display("serial test done");
        summarize();
    end
endmodule : sensor_source_priority_selector_test

// file: sim/ssps_selector_assertions.sv
`timescale 1ns/1ps
module ssps_selector_chk
    import ssps_pkg::*;
#(
    parameter int NPORT = 6,
    parameter int TIMEOUT_CYC = 200,
    parameter int STALE_CYC = 1000
) (
    // Clock and reset
    input wire logic ref_clk, input wire logic rstn,
    // Sentence in
    input wire logic sent_stb, input wire logic [2:0] sent_port, input wire logic [3:0] sent_kind,
    input wire logic sent_datum_ok, input wire logic [3:0] sent_fix_quality,
    input wire logic [NPORT-1:0] compat_mode,
    // Serial and interrogation
    input wire logic [5:0] ser_week, input wire logic [3:0] ser_years, input wire logic [10:0] ser_count,
    input wire logic interrog_stb, input wire logic [5:0] interrog_msg_id,
    // Outputs
    input wire logic fwd_stb, input wire logic [2:0] fwd_port, input wire logic [3:0] fwd_kind,
    input wire logic [3:0] fwd_fix_quality,
    input wire logic pos_valid, input wire logic [2:0] pos_port, input wire logic cog_valid,
    input wire logic [2:0] cog_port, input wire logic hdg_valid, input wire logic [2:0] hdg_port,
    input wire logic rot_valid, input wire logic [2:0] rot_port,
    input wire logic reply_stb, input wire logic [5:0] reply_msg_id, input wire logic [19:0] reply_serial
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    int hdg_quiet_ff;
    // Heading silence since selection or last forwarded heading
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) hdg_quiet_ff <= 0;
        else if (!hdg_valid || $changed(hdg_port) || (fwd_stb && (fwd_kind == 4'hb || fwd_kind == 4'hc)))
            hdg_quiet_ff <= 0;
        else hdg_quiet_ff <= hdg_quiet_ff + 1;
    end
    // Selection may move in the same cycle, so either side of it is accepted
    property from_src(logic [3:0] lo, logic [3:0] hi, logic v, logic [2:0] p);
        fwd_stb && fwd_kind >= lo && fwd_kind <= hi |-> (v && fwd_port == p) || ($past(v) && fwd_port == $past(p));
    endproperty
    fwd_echo_a: assert property (fwd_stb |-> $past(sent_stb) && fwd_port == $past(sent_port)
        && fwd_kind == $past(sent_kind)) else $error("forwarded sentence has no matching input");
    other_pass_a: assert property (sent_stb && sent_kind >= 4'he |=> fwd_stb)
        else $error("unfiltered sentence not forwarded");
    pos_filter_a: assert property (from_src(4'h0, 4'h8, pos_valid, pos_port))
        else $error("position sentence forwarded from wrong port");
    cog_filter_a: assert property (from_src(4'h9, 4'ha, cog_valid, cog_port))
        else $error("course sentence forwarded from wrong port");
    hdg_filter_a: assert property (from_src(4'hb, 4'hc, hdg_valid, hdg_port))
        else $error("heading sentence forwarded from wrong port");
    rot_filter_a: assert property (from_src(4'hd, 4'hd, rot_valid, rot_port))
        else $error("turn rate sentence forwarded from wrong port");
    fix_compat_a: assert property (fwd_stb && fwd_port < NPORT && compat_mode[fwd_port] |->
        fwd_fix_quality == {3'h0, $past(sent_fix_quality) != 4'h0}) else $error("compat fix wrong");
    fix_plain_a: assert property (fwd_stb && fwd_port < NPORT && !compat_mode[fwd_port] |->
        fwd_fix_quality == $past(sent_fix_quality)) else $error("standard fix wrong");
    reply_time_a: assert property (interrog_stb && interrog_msg_id == 6'h0f |-> ##2 reply_stb)
        else $error("reply missing");
    reply_cause_a: assert property (reply_stb |-> $past(interrog_stb, 2) && $past(interrog_msg_id, 2) == 6'h0f
        && reply_msg_id == 6'h18) else $error("reply without request");
    serial_pack_a: assert property (reply_stb |-> reply_serial ==
        {$past(ser_week, 2), $past(ser_years[2:0], 2), $past(ser_count, 2)}) else $error("serial packing wrong");
    hdg_timeout_a: assert property (hdg_quiet_ff <= TIMEOUT_CYC + 4)
        else $error("heading source held past silence limit");
    cover property (hdg_valid && hdg_port == 3'h0);
    cover property (reply_stb);
    cover property (fwd_stb && fwd_kind <= 4'h8);
endmodule : ssps_selector_chk

bind ssps_selector ssps_selector_chk #(.NPORT(NPORT), .TIMEOUT_CYC(TIMEOUT_CYC), .STALE_CYC(STALE_CYC)) u_chk (
    .ref_clk(ref_clk), .rstn(rstn), .sent_stb(sent_stb), .sent_port(sent_port), .sent_kind(sent_kind),
    .sent_datum_ok(sent_datum_ok), .sent_fix_quality(sent_fix_quality), .compat_mode(compat_mode),
    .ser_week(ser_week), .ser_years(ser_years), .ser_count(ser_count), .interrog_stb(interrog_stb),
    .interrog_msg_id(interrog_msg_id), .fwd_stb(fwd_stb), .fwd_port(fwd_port), .fwd_kind(fwd_kind),
    .fwd_fix_quality(fwd_fix_quality), .pos_valid(pos_valid), .pos_port(pos_port), .cog_valid(cog_valid),
    .cog_port(cog_port), .hdg_valid(hdg_valid), .hdg_port(hdg_port), .rot_valid(rot_valid), .rot_port(rot_port),
    .reply_stb(reply_stb), .reply_msg_id(reply_msg_id), .reply_serial(reply_serial));

// file: sim/ssps_sensor_model.sv
`timescale 1ns/1ps
module ssps_sensor_model (
    // Clock
    input wire logic clk,
    // Parsed sentence toward the selector
    output logic sent_stb,
    output logic [2:0] sent_port,
    output logic [3:0] sent_kind,
    output logic sent_datum_ok,
    output logic [3:0] sent_fix_quality
);
    initial begin
        sent_stb = 1'b0;
        sent_port = 3'h0;
        sent_kind = 4'h0;
        sent_datum_ok = 1'b0;
        sent_fix_quality = 4'h0;
    end
    // One sentence; fields invert afterwards so stale values differ from the ones sent
    task put(input logic [2:0] p, input logic [3:0] k, input logic d, input logic [3:0] q);
        @(negedge clk);
        sent_stb = 1'b1;
        sent_port = p;
        sent_kind = k;
        sent_datum_ok = d;
        sent_fix_quality = q;
        @(negedge clk);
        sent_stb = 1'b0;
        sent_port = ~p;
        sent_kind = ~k;
        sent_datum_ok = ~d;
        sent_fix_quality = ~q;
    endtask : put
endmodule : ssps_sensor_model
